// >>> hdl/priority_fields_c_defines.vh
// constants for the interrupt priority and event code resolver
// assumes: included by the resolver modules, one clock, synchronous reset
// What this block does
// - two event code registers; every source has a code of its own
// - every accepted interrupt branches to one shared handler start address
// - external, port and DMA sources load a level code H'200-3C0, plus own code; timers own code in both
// - software sets levels 0-15 per source group in five 4-bit field registers
// - reset clears every programmable priority field to level 0
// - equal levels: nonmaskable, then debug port, then sources in listed order
// - nonmaskable is level 16, code H'1C0; debug port code H'5E0 in both
// - sources sharing one field rank from first listed down to last listed
// - debug port request sits at fixed level 15, not writable
// - accepting an interrupt never changes the core's four mask bits
`ifndef PRIORITY_FIELDS_C_DEFINES_VH
`define PRIORITY_FIELDS_C_DEFINES_VH

// register byte offsets
`define PRIORITY_FIELDS_C_OFF_PRIO_A 8'h00
`define PRIORITY_FIELDS_C_OFF_PRIO_B 8'h04
`define PRIORITY_FIELDS_C_OFF_PRIO_C 8'h08
`define PRIORITY_FIELDS_C_OFF_PRIO_D 8'h0C
`define PRIORITY_FIELDS_C_OFF_PRIO_E 8'h10
`define PRIORITY_FIELDS_C_OFF_LVL_CODE 8'h14
`define PRIORITY_FIELDS_C_OFF_SRC_CODE 8'h18
`define PRIORITY_FIELDS_C_OFF_STATUS 8'h1C
`define PRIORITY_FIELDS_C_OFF_MASK 8'h20
`define PRIORITY_FIELDS_C_OFF_PENDING 8'h24

// reset values
`define PRIORITY_FIELDS_C_PRIO_RESET 16'h0000
`define PRIORITY_FIELDS_C_CODE_RESET 12'h000

// status bit positions
`define PRIORITY_FIELDS_C_ST_ACCEPT 0
`define PRIORITY_FIELDS_C_ST_NMI 1
`define PRIORITY_FIELDS_C_ST_W 2

// fixed levels and codes
`define PRIORITY_FIELDS_C_NMI_LEVEL 5'h10
`define PRIORITY_FIELDS_C_DBG_LEVEL 5'h0F
`define PRIORITY_FIELDS_C_NMI_CODE 12'h1C0
`define PRIORITY_FIELDS_C_DBG_CODE 12'h5E0
`define PRIORITY_FIELDS_C_LVL_CODE_BASE 12'h200
`define PRIORITY_FIELDS_C_CODE_STEP 12'h020

// source index layout, in default order
`define PRIORITY_FIELDS_C_N_SRC 37
`define PRIORITY_FIELDS_C_IDX_NMI 6'h00
`define PRIORITY_FIELDS_C_IDX_DBG 6'h01
`define PRIORITY_FIELDS_C_IDX_EXT0 6'h02
`define PRIORITY_FIELDS_C_IDX_PORT0 6'h08
`define PRIORITY_FIELDS_C_IDX_DMA0 6'h0A
`define PRIORITY_FIELDS_C_IDX_TMR0 6'h17

// own code bases for each contiguous run of sources
`define PRIORITY_FIELDS_C_CODE_EXT 12'h600
`define PRIORITY_FIELDS_C_CODE_PORT 12'h700
`define PRIORITY_FIELDS_C_CODE_DMA 12'h800
`define PRIORITY_FIELDS_C_CODE_TMR 12'h400

`endif

// >>> hdl/priority_fields_c_pick.v
// highest-level request picker with fixed tie order
// assumes: lower index means earlier in the default order
`timescale 1ns/1ps
module priority_fields_c_pick #(
   parameter N = 37,
   parameter W = 5,
   parameter IW = 6
) (
   // requests and their levels
   input wire [N-1:0] req,
   input wire [N*W-1:0] lvl,
   // winner
   output reg hit,
   output reg [IW-1:0] idx,
   output reg [W-1:0] best
);
   integer i;
   always @* begin
      hit = 1'b0;
      idx = {IW{1'b0}};
      best = {W{1'b0}};
      // strict compare keeps the earliest listed source on a tie
      for (i = 0; i < N; i = i + 1) begin
         if (req[i] && (lvl[i*W +: W] > best)) begin
            hit = 1'b1;
            idx = i[IW-1:0];
            best = lvl[i*W +: W];
         end
      end
   end
endmodule // priority_fields_c_pick

// >>> hdl/priority_fields_c_resolver.v
// interrupt priority resolver with event code capture and axi4-lite registers
// assumes: requests are levels synchronous to clock, held until accepted;
// the core pulses core_ack for one cycle while core_req is high
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "priority_fields_c_defines.vh"
module priority_fields_c_resolver #(
   parameter N_SRC = `PRIORITY_FIELDS_C_N_SRC,
   parameter [31:0] HANDLER_ADDR = 32'h0000_0600
) (
   // clock and reset
   input wire clock,
   input wire nrst,
   // requests: bit 0 nonmaskable, bit 1 debug port, then listed order
   input wire [N_SRC-1:0] src_req,
   // processor core
   input wire [3:0] core_mask,
   input wire core_ack,
   output reg core_req_q,
   output reg [4:0] core_level_q,
   output reg accept_q,
   output reg [31:0] handler_addr_q,
   output reg [11:0] level_event_code_q,
   output reg [11:0] source_event_code_q,
   output reg irq_q,
   // axi4-lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   localparam [1:0] RESP_OK = 2'b00;
   localparam [1:0] RESP_ERR = 2'b10;

   reg [15:0] priority_fields_a_q;
   reg [15:0] priority_fields_b_q;
   reg [15:0] priority_fields_c_q;
   reg [15:0] priority_fields_d_q;
   reg [15:0] priority_fields_e_q;
   reg [`PRIORITY_FIELDS_C_ST_W-1:0] status_q;
   reg [`PRIORITY_FIELDS_C_ST_W-1:0] status_d;
   reg [`PRIORITY_FIELDS_C_ST_W-1:0] mask_q;
   reg [5:0] win_idx_q;
   reg [4:0] win_lvl_q;
   reg [7:0] aw_addr_q;
   reg aw_held_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_held_q;

   wire [79:0] fields;
   reg [N_SRC*5-1:0] levels;
   wire hit;
   wire [5:0] pick_idx;
   wire [4:0] pick_lvl;
   integer k;

   assign fields = {priority_fields_e_q, priority_fields_d_q, priority_fields_c_q,
      priority_fields_b_q, priority_fields_a_q};

   // nibble slot of the shared field for each programmable source
   function [4:0] field_slot;
      input [5:0] i;
      begin
         case (i)
            6'h02, 6'h03, 6'h04, 6'h05: field_slot = 5'h08 + {2'b00, i[2:0]} - 5'h02;
            6'h06: field_slot = 5'h0C;
            6'h07: field_slot = 5'h0D;
            6'h08: field_slot = 5'h0F;
            6'h09: field_slot = 5'h0E;
            6'h0A, 6'h0B, 6'h0C, 6'h0D: field_slot = 5'h13;
            6'h0E, 6'h0F, 6'h10, 6'h11: field_slot = 5'h12;
            6'h12, 6'h13, 6'h14, 6'h15: field_slot = 5'h11;
            6'h16: field_slot = 5'h10;
            6'h17: field_slot = 5'h03;
            6'h18: field_slot = 5'h02;
            6'h19, 6'h1A: field_slot = 5'h01;
            6'h1B, 6'h1C, 6'h1D: field_slot = 5'h00;
            6'h1E, 6'h1F, 6'h20, 6'h21: field_slot = 5'h04;
            6'h22: field_slot = 5'h07;
            6'h23, 6'h24: field_slot = 5'h06;
            default: field_slot = 5'h05;
         endcase
      end
   endfunction

   // own code of each source
   function [11:0] own_code;
      input [5:0] i;
      reg [5:0] off;
      begin
         off = 6'h00;
         if (i == `PRIORITY_FIELDS_C_IDX_NMI) begin
            own_code = `PRIORITY_FIELDS_C_NMI_CODE;
         end else if (i == `PRIORITY_FIELDS_C_IDX_DBG) begin
            own_code = `PRIORITY_FIELDS_C_DBG_CODE;
         end else if (i < `PRIORITY_FIELDS_C_IDX_PORT0) begin
            off = i - `PRIORITY_FIELDS_C_IDX_EXT0;
            own_code = `PRIORITY_FIELDS_C_CODE_EXT + {1'b0, off, 5'h00};
         end else if (i < `PRIORITY_FIELDS_C_IDX_DMA0) begin
            off = i - `PRIORITY_FIELDS_C_IDX_PORT0;
            own_code = `PRIORITY_FIELDS_C_CODE_PORT + {1'b0, off, 5'h00};
         end else if (i < `PRIORITY_FIELDS_C_IDX_TMR0) begin
            off = i - `PRIORITY_FIELDS_C_IDX_DMA0;
            own_code = `PRIORITY_FIELDS_C_CODE_DMA + {1'b0, off, 5'h00};
         end else begin
            off = i - `PRIORITY_FIELDS_C_IDX_TMR0;
            own_code = `PRIORITY_FIELDS_C_CODE_TMR + {1'b0, off, 5'h00};
         end
      end
   endfunction

   // level table for the picker
   always @* begin
      levels = {(N_SRC*5){1'b0}};
      for (k = 0; k < N_SRC; k = k + 1) begin
         if (k == 0) begin
            levels[k*5 +: 5] = `PRIORITY_FIELDS_C_NMI_LEVEL;
         end else if (k == 1) begin
            levels[k*5 +: 5] = `PRIORITY_FIELDS_C_DBG_LEVEL;
         end else begin
            levels[k*5 +: 5] = {1'b0, fields[field_slot(k[5:0])*4 +: 4]};
         end
      end
   end

   priority_fields_c_pick #(
      .N(N_SRC),
      .W(5),
      .IW(6)
   ) i_priority_fields_c_pick (
      .req(src_req),
      .lvl(levels),
      .hit(hit),
      .idx(pick_idx),
      .best(pick_lvl)
   );

   // resolution and acceptance
   always @(posedge clock) begin
      if (!nrst) begin
         win_idx_q <= 6'h00;
         win_lvl_q <= 5'h00;
         core_req_q <= 1'b0;
         core_level_q <= 5'h00;
         accept_q <= 1'b0;
         handler_addr_q <= 32'h0000_0000;
         level_event_code_q <= `PRIORITY_FIELDS_C_CODE_RESET;
         source_event_code_q <= `PRIORITY_FIELDS_C_CODE_RESET;
      end else begin
         win_idx_q <= pick_idx;
         win_lvl_q <= pick_lvl;
         // a winner at level 0 never gets here; core mask is only read
         core_req_q <= hit && (pick_lvl > {1'b0, core_mask})
            && !(core_req_q && core_ack);
         core_level_q <= pick_lvl;
         accept_q <= core_req_q && core_ack;
         if (core_req_q && core_ack) begin
            handler_addr_q <= HANDLER_ADDR;
            source_event_code_q <= own_code(win_idx_q);
            if (win_idx_q >= `PRIORITY_FIELDS_C_IDX_EXT0 && win_idx_q < `PRIORITY_FIELDS_C_IDX_TMR0) begin
               level_event_code_q <= `PRIORITY_FIELDS_C_LVL_CODE_BASE
                  + {3'b000, 4'hF - win_lvl_q[3:0], 5'h00};
            end else begin
               level_event_code_q <= own_code(win_idx_q);
            end
         end
      end
   end

   // sticky events: a new event beats a same-cycle clear
   always @* begin
      status_d = status_q;
      if (aw_held_q && w_held_q && !s_axi_bvalid && aw_addr_q == `PRIORITY_FIELDS_C_OFF_STATUS
         && w_strb_q[0]) begin
         status_d = status_d & ~w_data_q[`PRIORITY_FIELDS_C_ST_W-1:0];
      end
      if (core_req_q && core_ack) begin
         status_d[`PRIORITY_FIELDS_C_ST_ACCEPT] = 1'b1;
         if (win_idx_q == `PRIORITY_FIELDS_C_IDX_NMI) begin
            status_d[`PRIORITY_FIELDS_C_ST_NMI] = 1'b1;
         end
      end
   end

   // axi4-lite write path
   always @(posedge clock) begin
      if (!nrst) begin
         priority_fields_a_q <= `PRIORITY_FIELDS_C_PRIO_RESET;
         priority_fields_b_q <= `PRIORITY_FIELDS_C_PRIO_RESET;
         priority_fields_c_q <= `PRIORITY_FIELDS_C_PRIO_RESET;
         priority_fields_d_q <= `PRIORITY_FIELDS_C_PRIO_RESET;
         priority_fields_e_q <= `PRIORITY_FIELDS_C_PRIO_RESET;
         status_q <= {`PRIORITY_FIELDS_C_ST_W{1'b0}};
         mask_q <= {`PRIORITY_FIELDS_C_ST_W{1'b0}};
         irq_q <= 1'b0;
         aw_addr_q <= 8'h00;
         aw_held_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         w_held_q <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OK;
      end else begin
         status_q <= status_d;
         irq_q <= |(status_d & mask_q);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
            aw_held_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_held_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_held_q && w_held_q && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OK;
            case (aw_addr_q)
               `PRIORITY_FIELDS_C_OFF_PRIO_A: begin
                  if (w_strb_q[0]) priority_fields_a_q[7:0] <= w_data_q[7:0];
                  if (w_strb_q[1]) priority_fields_a_q[15:8] <= w_data_q[15:8];
               end
               `PRIORITY_FIELDS_C_OFF_PRIO_B: begin
                  if (w_strb_q[0]) priority_fields_b_q[7:0] <= w_data_q[7:0];
                  if (w_strb_q[1]) priority_fields_b_q[15:8] <= w_data_q[15:8];
               end
               `PRIORITY_FIELDS_C_OFF_PRIO_C: begin
                  if (w_strb_q[0]) priority_fields_c_q[7:0] <= w_data_q[7:0];
                  if (w_strb_q[1]) priority_fields_c_q[15:8] <= w_data_q[15:8];
               end
               `PRIORITY_FIELDS_C_OFF_PRIO_D: begin
                  if (w_strb_q[0]) priority_fields_d_q[7:0] <= w_data_q[7:0];
                  if (w_strb_q[1]) priority_fields_d_q[15:8] <= w_data_q[15:8];
               end
               `PRIORITY_FIELDS_C_OFF_PRIO_E: begin
                  if (w_strb_q[0]) priority_fields_e_q[7:0] <= w_data_q[7:0];
                  if (w_strb_q[1]) priority_fields_e_q[15:8] <= w_data_q[15:8];
               end
               `PRIORITY_FIELDS_C_OFF_MASK: begin
                  if (w_strb_q[0]) mask_q <= w_data_q[`PRIORITY_FIELDS_C_ST_W-1:0];
               end
               `PRIORITY_FIELDS_C_OFF_STATUS, `PRIORITY_FIELDS_C_OFF_LVL_CODE, `PRIORITY_FIELDS_C_OFF_SRC_CODE,
               `PRIORITY_FIELDS_C_OFF_PENDING: begin
                  s_axi_bresp <= RESP_OK;
               end
               default: s_axi_bresp <= RESP_ERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // axi4-lite read path; one read in flight, answered the cycle after it is taken
   always @(posedge clock) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OK;
         case (s_axi_araddr)
            `PRIORITY_FIELDS_C_OFF_PRIO_A: s_axi_rdata <= {16'h0000, priority_fields_a_q};
            `PRIORITY_FIELDS_C_OFF_PRIO_B: s_axi_rdata <= {16'h0000, priority_fields_b_q};
            `PRIORITY_FIELDS_C_OFF_PRIO_C: s_axi_rdata <= {16'h0000, priority_fields_c_q};
            `PRIORITY_FIELDS_C_OFF_PRIO_D: s_axi_rdata <= {16'h0000, priority_fields_d_q};
            `PRIORITY_FIELDS_C_OFF_PRIO_E: s_axi_rdata <= {16'h0000, priority_fields_e_q};
            `PRIORITY_FIELDS_C_OFF_LVL_CODE: s_axi_rdata <= {20'h00000, level_event_code_q};
            `PRIORITY_FIELDS_C_OFF_SRC_CODE: s_axi_rdata <= {20'h00000, source_event_code_q};
            `PRIORITY_FIELDS_C_OFF_STATUS: s_axi_rdata <= {30'h0000_0000, status_q};
            `PRIORITY_FIELDS_C_OFF_MASK: s_axi_rdata <= {30'h0000_0000, mask_q};
            `PRIORITY_FIELDS_C_OFF_PENDING: s_axi_rdata <= {19'h00000, core_req_q, 1'b0, win_lvl_q,
               win_idx_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_ERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule // priority_fields_c_resolver

// >>> testbench/priority_fields_c_resolver_properties.sv
// checker for the interrupt priority resolver, bound to its ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module priority_fields_c_checker #(
   parameter [31:0] HANDLER_ADDR = 32'h0000_0600
) (
   // clock and reset
   input logic clock,
   input logic nrst,
   // core link
   input logic [3:0] core_mask,
   input logic core_ack,
   input logic core_req_q,
   input logic [4:0] core_level_q,
   input logic accept_q,
   input logic [31:0] handler_addr_q,
   input logic [11:0] level_event_code_q,
   input logic [11:0] source_event_code_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   a_ack_accept: assert property (core_req_q && core_ack |=> accept_q ##1 !accept_q)
      else $error("ack without one accept pulse");
   a_handler_addr: assert property (accept_q |-> handler_addr_q == HANDLER_ADDR)
      else $error("wrong handler address");
   a_req_mask: assert property (core_req_q |-> core_level_q > {1'b0, $past(core_mask)})
      else $error("request not above mask");
   a_nmi_code: assert property (accept_q && $past(core_level_q) == 5'h10
      |-> level_event_code_q == 12'h1C0 && source_event_code_q == 12'h1C0)
      else $error("bad nonmaskable codes");
   a_dbg_code: assert property (accept_q && source_event_code_q == 12'h5E0
      |-> level_event_code_q == 12'h5E0 && $past(core_level_q) == 5'h0F)
      else $error("bad debug port codes");
   a_level_code: assert property (accept_q && source_event_code_q inside {[12'h600:12'h980]}
      |-> level_event_code_q == 12'h3E0 - {2'h0, $past(core_level_q), 5'h00})
      else $error("bad level code");
   a_own_code: assert property (accept_q && source_event_code_q inside {[12'h400:12'h5A0]}
      |-> level_event_code_q == source_event_code_q)
      else $error("own code not in both");
   a_codes_stand: assert property (!accept_q |-> $stable(level_event_code_q)
      && $stable(source_event_code_q))
      else $error("codes moved without accept");
endmodule // priority_fields_c_checker

bind priority_fields_c_resolver priority_fields_c_checker #(.HANDLER_ADDR(HANDLER_ADDR)) i_priority_fields_c_checker (.clock, .nrst,
   .core_mask, .core_ack, .core_req_q, .core_level_q, .accept_q, .handler_addr_q,
   .level_event_code_q, .source_event_code_q);

// >>> testbench/priority_fields_c_core_model.sv
// processor core model: holds the mask level, acknowledges requests after a delay
// assumes requests stay up until accepted
`timescale 1ns/1ps
module priority_fields_c_core_model (
   // clock and reset
   input logic clock,
   input logic nrst,
   // core link
   input logic core_req_q,
   input logic [3:0] mask_set,
   input logic [2:0] ack_delay,
   output logic core_ack,
   output logic [3:0] core_mask
);
   logic [2:0] wait_q;
   // the mask belongs to the core; the resolver only reads it
   assign core_mask = mask_set;
   // delay of two or more: levels are released one cycle after the accept
   always @(posedge clock) begin
      if (!nrst || !core_req_q || core_ack) begin
         wait_q <= 3'h0;
         core_ack <= 1'b0;
      end else if (wait_q >= ack_delay)
         core_ack <= 1'b1;
      else
         wait_q <= wait_q + 3'h1;
   end
endmodule // priority_fields_c_core_model

// >>> testbench/priority_fields_c_resolver_tb.sv
// self-checking bench for the interrupt priority resolver
// assumes the core model on the far side and the bound checker
`timescale 1ns/1ps
module priority_fields_c_resolver_tb;
   logic clock = 0;
   logic nrst = 0;
   logic [36:0] src_req = '0;
   logic [3:0] mask_set = 4'h0;
   logic [2:0] ack_delay = 3'h2;
   logic [3:0] core_mask;
   logic core_ack, core_req_q, accept_q, irq_q;
   logic [4:0] core_level_q;
   logic [31:0] handler_addr_q, s_axi_rdata, rdat, v;
   logic [31:0] seed = 32'h3598;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [11:0] level_event_code_q, source_event_code_q;
   logic [7:0] s_axi_awaddr = 8'h0;
   logic [7:0] s_axi_araddr = 8'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
   int bad_count = 0, samples_checked = 0, k, m, j, l, n;
   priority_fields_c_resolver i_priority_fields_c_resolver (.clock, .nrst, .src_req, .core_mask, .core_ack, .core_req_q,
      .core_level_q, .accept_q, .handler_addr_q, .level_event_code_q, .source_event_code_q,
      .irq_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   priority_fields_c_core_model i_priority_fields_c_core_model (.clock, .nrst, .core_req_q, .mask_set, .ack_delay,
      .core_ack, .core_mask);
   initial forever #2 clock = ~clock;
   function automatic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // {register index, nibble} of the field that sets source k
   function automatic [4:0] slot(input int k);
      if (k < 6) return {3'h2, 2'(k - 2)};
      if (k < 10) return {3'h3, k < 8 ? 2'(k - 6) : 2'(11 - k)};
      if (k < 23) return {3'h4, 2'(3 - (k - 10) / 4)};
      if (k < 27) return {3'h0, k < 25 ? 2'(26 - k) : 2'h1};
      if (k < 30) return 5'h00;
      return {3'h1, k < 34 ? 2'h0 : (k == 34 ? 2'h3 : 2'h2)};
   endfunction
   function automatic [11:0] scode(input int k);
      if (k < 8) return 12'(12'h600 + (k - 2) * 32);
      if (k < 10) return 12'(12'h700 + (k - 8) * 32);
      if (k < 23) return 12'(12'h800 + (k - 10) * 32);
      return 12'(12'h400 + (k - 23) * 32);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      if (bad_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic hang(input string nm);
      bad_count++;
      $display("ERROR %s expected answer seen timeout", nm);
      tally_and_finish();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      if (n == 50) hang("write");
      s_axi_bready <= 1'b0;
      chk("write resp", er, s_axi_bresp);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      if (n == 50) hang("read");
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic wacc();
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (accept_q !== 1'b1 && n < 100);
      if (n == 100) hang("accept");
   endtask
   task automatic setlvl(input int k, input int l);
      logic [4:0] s;
      s = slot(k);
      v = rnd();
      v[s[1:0] * 4 +: 4] = 4'(l);
      wr({3'h0, s[4:2], 2'h0}, v, 2'h0);
   endtask
   initial begin
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      for (k = 0; k < 11; k++) begin
         rd(8'(k * 4));
         if (k < 10) chk("reset value", 32'h0, rdat);
         chk("read resp", k == 10 ? 2'h2 : 2'h0, rrsp);
      end
      wr(8'h28, 32'hFFFF, 2'h2);
      wr(8'h14, 32'h3FF, 2'h0);
      rd(8'h14);
      chk("read-only code", 32'h0, rdat);
      chk("handler reset", 32'h0, handler_addr_q);
      src_req <= 37'h1F_FFFF_FFFC;
      repeat (4) @(posedge clock);
      chk("level zero request", 32'h0, core_req_q);
      src_req <= '0;
      for (k = 0; k < 5; k++) begin
         v = rnd();
         wr(8'(k * 4), v, 2'h0);
         rd(8'(k * 4));
         m = k == 1 ? 32'hFF0F : 32'hFFFF;
         chk("priority field", v & m, rdat & m);
      end
      rd(8'h00);
      v = rdat;
      s_axi_wstrb <= 4'h1;
      wr(8'h00, 32'h0000_A5A5, 2'h0);
      s_axi_wstrb <= 4'hF;
      rd(8'h00);
      chk("byte strobe", {16'h0000, v[15:8], 8'hA5}, rdat);
      for (j = 0; j < 30; j++) begin
         k = 2 + rnd() % 35;
         l = 1 + rnd() % 15;
         ack_delay <= 3'(2 + rnd() % 4);
         setlvl(k, l);
         mask_set <= 4'(l);
         src_req[k] <= 1'b1;
         repeat (4) @(posedge clock);
         chk("masked request", 32'h0, core_req_q);
         mask_set <= 4'(l - 1);
         wacc();
         chk("source code", scode(k), source_event_code_q);
         chk("level code", k < 23 ? 32'h3E0 - l * 32 : scode(k), level_event_code_q);
         chk("handler address", 32'h600, handler_addr_q);
         src_req[k] <= 1'b0;
      end
      for (j = 0; j < 10; j++) begin
         l = 1 + rnd() % 15;
         for (k = 0; k < 5; k++) wr(8'(k * 4), {4{4'(l)}}, 2'h0);
         mask_set <= 4'(rnd() % l);
         k = 2 + rnd() % 34;
         m = k + 1 + rnd() % (36 - k);
         src_req[k] <= 1'b1;
         src_req[m] <= 1'b1;
         wacc();
         chk("tie winner", scode(k), source_event_code_q);
         src_req[k] <= 1'b0;
         wacc();
         chk("tie loser", scode(m), source_event_code_q);
         src_req[m] <= 1'b0;
      end
      mask_set <= 4'hF;
      src_req[1:0] <= 2'h3;
      wacc();
      chk("nonmaskable codes", 32'h1C01C0, {level_event_code_q, source_event_code_q});
      src_req[0] <= 1'b0;
      rd(8'h1C);
      chk("status", 32'h3, rdat);
      chk("irq masked", 32'h0, irq_q);
      chk("debug refused", 32'h0, core_req_q);
      rd(8'h24);
      chk("pending winner", 32'h3C1, rdat);
      wr(8'h20, 32'h1, 2'h0);
      repeat (2) @(posedge clock);
      chk("irq raised", 32'h1, irq_q);
      wr(8'h1C, 32'h3, 2'h0);
      repeat (2) @(posedge clock);
      chk("irq cleared", 32'h0, irq_q);
      mask_set <= 4'hE;
      wacc();
      chk("debug codes", 32'h5E05E0, {level_event_code_q, source_event_code_q});
      src_req[1] <= 1'b0;
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      rd(8'h00);
      chk("reset again", 32'h0, rdat);
      tally_and_finish();
   end
endmodule // priority_fields_c_resolver_tb
